// ---- hw/scb_defines.svh ----
// Purpose: offsets, field positions, reset values and codes of the system control block
// Assumes: 16-bit i/o port data, word port addresses
// Notes:   definitions only
`ifndef SCB_DEFINES_SVH
`define SCB_DEFINES_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define SCB_SYSCTL_ADDR      16'h07fd
`define SCB_SYSCTL_RST       16'h0200
`define SCB_SYSCTL_WMASK     16'h0397
`define SCB_BIT_PULL_EN      9
`define SCB_BIT_EMEM_HOLD    8
`define SCB_BIT_HOST_HOLD    7
`define SCB_BIT_BOOT3        6
`define SCB_BIT_MBZ          4
`define SCB_DIV_MSB          2

// ----------------------------------------------------------------------------
// boot start addresses (byte addresses)
// ----------------------------------------------------------------------------
`define SCB_RESET_VECTOR     24'hffff00
`define SCB_SINGLE_ACCESS_RAM_START      24'h010000
`define SCB_TABLE_START      24'h000000

`endif

// ---- hw/scb_pkg.sv ----
// Purpose: types of the system control block
// Assumes: nothing
// Notes:   boot sources are one-hot
package scb_pkg;

  // --------------------------------------------------------------------------
  // boot source decode
  // --------------------------------------------------------------------------
  typedef enum logic [6:0] {
    SCB_BOOT_NONE   = 7'h01,
    SCB_BOOT_SPI24  = 7'h02,
    SCB_BOOT_SPI16  = 7'h04,
    SCB_BOOT_PAR    = 7'h08,
    SCB_BOOT_HOST   = 7'h10,
    SCB_BOOT_SER16  = 7'h20,
    SCB_BOOT_SER8   = 7'h40
  } scb_boot_type;

  typedef struct packed {
    logic       pull_en;
    logic       emem_hold;
    logic       host_hold;
    logic       mbz;
    logic [2:0] divide;
  } scb_ctl_type;

  typedef struct packed {
    scb_boot_type boot_src;
    logic [1:0]   par_width;    // 0:8 1:16 2:32 bits
    logic [23:0]  start_addr;
  } scb_boot_info_type;

endpackage : scb_pkg

// ---- hw/scb_clk_div.sv ----
// Purpose: clock output divider
// Assumes: runs on the cpu clock, never touches the pll
// Notes:   code 0 passes the clock through, otherwise divides by 2*code
`timescale 1ns/100ps
`include "scb_defines.svh"

module scb_clk_div (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // control
  input  wire logic [2:0] i_div,
  // outputs
  output logic            o_bypass,
  output logic            o_half
);

  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       half_r;
  logic       half_nxt;
  logic       byp_r;
  logic [2:0] half_len;

  // half period in cpu clocks: 1 for code 1, code value otherwise
  assign half_len = (i_div == 3'h1) ? 3'h1 : i_div;

  // counter runs every clock; a new code already sets the end of the half period in progress
  always_comb begin
    cnt_nxt  = cnt_r + 3'h1;
    half_nxt = half_r;
    if (cnt_nxt >= half_len) begin
      cnt_nxt  = 3'h0;
      half_nxt = ~half_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_r  <= 3'h0;
      half_r <= 1'b0;
      byp_r  <= 1'b1;
    end else begin
      cnt_r  <= cnt_nxt;
      half_r <= half_nxt;
      byp_r  <= (i_div == 3'h0);
    end
  end

  assign o_bypass = byp_r;
  assign o_half   = half_r;

endmodule : scb_clk_div

// ---- hw/scb_sysctl.sv ----
// Purpose: system control register on i/o port space plus boot select capture
// Assumes: one cpu clock, asynchronous active-low hardware reset
// Notes:   clock output in bypass mode is the cpu clock gated by a flop-held select
//
// Functional notes
// - register decoded at one i/o port address
// - bits 15-10, 5, 3 read zero, ignore writes
// - bit 9 resets one, enables host pulls
// - bit 8 enables external memory bus holders
// - bit 7 enables host data bus holders
// - bit 6 reads boot select bit 3 pin
// - divide field: 1, 2, then twice code
// - divider only affects clock output pin
// - low boot pins latched at reset release
// - boot pins become gpio lines after reset
// - codes 0000, 1000 mean no boot
// - 0001/1001 spi eeprom boot, 24/16-bit address
// - 1010-1100 parallel boot, 8/16/32 bits
// - 1101 host port boot, start sram
// - 1110/1111 serial slave boot, 16/8-bit
// - boot bit 3 sampled during boot loader
`timescale 1ns/100ps
`include "scb_defines.svh"

module scb_sysctl (
  // clock and reset
  input  wire logic                      I_MCLK,
  input  wire logic                      I_NRST,
  // i/o port access
  input  wire logic [15:0]               I_PORT_ADDR,
  input  wire logic                      I_PORT_WR,
  input  wire logic                      I_PORT_RD,
  input  wire logic [15:0]               I_PORT_WDATA,
  output logic      [15:0]               O_PORT_RDATA,
  output logic                           O_PORT_RVALID,
  // pins
  input  wire logic [2:0]                I_BOOT_SELECT_LOW_BITS,
  input  wire logic                      I_BOOT_SELECT_BIT3,
  // boot loader handshake
  input  wire logic                      I_BOOT_LOADER_ACTIVE,
  // pad controls
  output logic                           O_HOST_PIN_PULL_ENABLE,
  output logic                           O_EXT_MEM_BUS_HOLDER_ENABLE,
  output logic                           O_HOST_DATA_BUS_HOLDER_ENABLE,
  output logic                           O_GPIO_STRAP_RELEASE,
  // boot selection
  output scb_pkg::scb_boot_info_type     O_BOOT_INFO,
  output logic      [3:0]                O_BOOT_CODE,
  // clock output
  output logic                           O_CLOCK_OUTPUT_PIN
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;

  // only the second stage is read downstream
  // no reset on these two stages on purpose: the straps must already stand
  // in the second stage at the first edge after release, or the capture
  // would take the reset zeros instead of the board levels
  // limitation: straps must be steady for two clocks before release, and
  // the stages show unknowns until the pins have been sampled twice
  always_ff @(posedge I_MCLK) begin
    pin_s1_r <= {I_BOOT_SELECT_BIT3, I_BOOT_SELECT_LOW_BITS};
    pin_s2_r <= pin_s1_r;
  end

  // --------------------------------------------------------------------------
  // register bank
  // --------------------------------------------------------------------------
  scb_pkg::scb_ctl_type ctl_r;
  scb_pkg::scb_ctl_type ctl_nxt;
  logic [15:0]          rdata_r;
  logic [15:0]          rdata_nxt;
  logic                 rvalid_r;
  logic                 hit;

  function automatic logic port_hit(input logic [15:0] addr);
    port_hit = (addr == `SCB_SYSCTL_ADDR);
  endfunction : port_hit

  assign hit = port_hit(I_PORT_ADDR);

  // writes touch only the writable bits; reserved bits have no storage
  always_comb begin
    ctl_nxt   = ctl_r;
    rdata_nxt = rdata_r;
    if (I_PORT_WR && hit) begin
      ctl_nxt.pull_en   = I_PORT_WDATA[`SCB_BIT_PULL_EN];
      ctl_nxt.emem_hold = I_PORT_WDATA[`SCB_BIT_EMEM_HOLD];
      ctl_nxt.host_hold = I_PORT_WDATA[`SCB_BIT_HOST_HOLD];
      ctl_nxt.mbz       = I_PORT_WDATA[`SCB_BIT_MBZ];
      ctl_nxt.divide    = I_PORT_WDATA[`SCB_DIV_MSB:0];
    end
    if (I_PORT_RD) begin
      rdata_nxt = 16'h0000;
      if (hit) begin
        rdata_nxt[`SCB_BIT_PULL_EN]   = ctl_r.pull_en;
        rdata_nxt[`SCB_BIT_EMEM_HOLD] = ctl_r.emem_hold;
        rdata_nxt[`SCB_BIT_HOST_HOLD] = ctl_r.host_hold;
        rdata_nxt[`SCB_BIT_BOOT3]     = pin_s2_r[3];
        rdata_nxt[`SCB_BIT_MBZ]       = ctl_r.mbz;
        rdata_nxt[`SCB_DIV_MSB:0]     = ctl_r.divide;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctl_r    <= scb_pkg::scb_ctl_type'(7'h40);
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      ctl_r    <= ctl_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= I_PORT_RD;
    end
  end

  // --------------------------------------------------------------------------
  // boot capture and decode
  // --------------------------------------------------------------------------
  logic [2:0]                low_r;
  logic [2:0]                low_nxt;
  logic                      cap_done_r;
  logic                      b3_r;
  logic                      b3_nxt;
  logic                      rel_r;
  scb_pkg::scb_boot_info_type info_r;
  scb_pkg::scb_boot_info_type info_nxt;

  // first clock after reset release takes the synchronised low straps once,
  // then the pins are handed back to gpio use
  always_comb begin
    low_nxt = low_r;
    b3_nxt  = b3_r;
    if (!cap_done_r) begin
      low_nxt = pin_s2_r[2:0];
    end
    if (I_BOOT_LOADER_ACTIVE) begin
      b3_nxt = pin_s2_r[3];
    end
  end

  // reserved codes fall back to no boot
  always_comb begin
    info_nxt.par_width  = 2'h0;
    info_nxt.start_addr = `SCB_TABLE_START;
    unique case ({b3_r, low_r})
      4'h1: info_nxt.boot_src = scb_pkg::SCB_BOOT_SPI24;
      4'h9: info_nxt.boot_src = scb_pkg::SCB_BOOT_SPI16;
      4'ha, 4'hb, 4'hc: begin
        info_nxt.boot_src  = scb_pkg::SCB_BOOT_PAR;
        info_nxt.par_width = 2'(low_r - 3'h2);
      end
      4'hd: begin
        info_nxt.boot_src   = scb_pkg::SCB_BOOT_HOST;
        info_nxt.start_addr = `SCB_SINGLE_ACCESS_RAM_START;
      end
      4'he: info_nxt.boot_src = scb_pkg::SCB_BOOT_SER16;
      4'hf: info_nxt.boot_src = scb_pkg::SCB_BOOT_SER8;
      default: begin
        info_nxt.boot_src   = scb_pkg::SCB_BOOT_NONE;
        info_nxt.start_addr = `SCB_RESET_VECTOR;
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      low_r      <= 3'h0;
      cap_done_r <= 1'b0;
      b3_r       <= 1'b0;
      rel_r      <= 1'b0;
      info_r     <= '{scb_pkg::SCB_BOOT_NONE, 2'h0, `SCB_RESET_VECTOR};
    end else begin
      low_r      <= low_nxt;
      cap_done_r <= 1'b1;
      b3_r       <= b3_nxt;
      rel_r      <= cap_done_r;
      info_r     <= info_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // clock output
  // --------------------------------------------------------------------------
  logic div_bypass;
  logic div_half;

  // divider is fed only from the register field; pll and cpu clock untouched
  scb_clk_div u_div (
    .i_clk    (I_MCLK),
    .i_nrst   (I_NRST),
    .i_div    (ctl_r.divide),
    .o_bypass (div_bypass),
    .o_half   (div_half)
  );

  // divide by one must show the clock itself; the select is a flop so no glitch logic
  assign O_CLOCK_OUTPUT_PIN = div_bypass ? I_MCLK : div_half;

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign O_PORT_RDATA                  = rdata_r;
  assign O_PORT_RVALID                 = rvalid_r;
  assign O_HOST_PIN_PULL_ENABLE        = ctl_r.pull_en;
  assign O_EXT_MEM_BUS_HOLDER_ENABLE   = ctl_r.emem_hold;
  assign O_HOST_DATA_BUS_HOLDER_ENABLE = ctl_r.host_hold;
  assign O_GPIO_STRAP_RELEASE          = rel_r;
  assign O_BOOT_INFO                   = info_r;
  assign O_BOOT_CODE                   = {b3_r, low_r};

endmodule : scb_sysctl

// ---- verif/scb_sysctl_properties.sv ----
// Purpose: port-level properties of the system control block
// Assumes: one clock, async active-low reset
// Notes:   attached by the bind at the foot
`timescale 1ns/100ps
module scb_sysctl_properties (
  input wire logic                       I_MCLK,
  input wire logic                       I_NRST,
  input wire logic [15:0]                I_PORT_ADDR,
  input wire logic                       I_PORT_WR,
  input wire logic                       I_PORT_RD,
  input wire logic [15:0]                I_PORT_WDATA,
  input wire logic [15:0]                O_PORT_RDATA,
  input wire logic                       O_PORT_RVALID,
  input wire logic                       O_HOST_PIN_PULL_ENABLE,
  input wire logic                       O_EXT_MEM_BUS_HOLDER_ENABLE,
  input wire logic                       O_HOST_DATA_BUS_HOLDER_ENABLE,
  input wire scb_pkg::scb_boot_info_type O_BOOT_INFO,
  input wire logic [3:0]                 O_BOOT_CODE
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);
  logic hit;
  logic miss;
  // writes split by whether they aim at the register
  assign hit  = I_PORT_WR && (I_PORT_ADDR == 16'h07fd);
  assign miss = I_PORT_WR && (I_PORT_ADDR != 16'h07fd);
  property p_rvalid; I_PORT_RD |=> O_PORT_RVALID; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_unmap; I_PORT_RD && I_PORT_ADDR != 16'h07fd |=> O_PORT_RDATA == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rsv; O_PORT_RVALID |-> {O_PORT_RDATA[15:10], O_PORT_RDATA[5], O_PORT_RDATA[3]} == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
  property p_other;
    miss |=> $stable({O_HOST_PIN_PULL_ENABLE, O_EXT_MEM_BUS_HOLDER_ENABLE,
                      O_HOST_DATA_BUS_HOLDER_ENABLE});
  endproperty
  a_other: assert property (p_other) else $error("foreign write changed pads");
  property p_pull; hit |=> O_HOST_PIN_PULL_ENABLE == $past(I_PORT_WDATA[9]); endproperty
  a_pull: assert property (p_pull) else $error("pull enable wrong");
  property p_emem; hit |=> O_EXT_MEM_BUS_HOLDER_ENABLE == $past(I_PORT_WDATA[8]); endproperty
  a_emem: assert property (p_emem) else $error("memory holder wrong");
  property p_hhold; hit |=> O_HOST_DATA_BUS_HOLDER_ENABLE == $past(I_PORT_WDATA[7]); endproperty
  a_hhold: assert property (p_hhold) else $error("host holder wrong");
  property p_none;
    O_BOOT_CODE[2:0] == 3'h0 ##1 O_BOOT_CODE[2:0] == 3'h0 |->
      O_BOOT_INFO.boot_src == scb_pkg::SCB_BOOT_NONE && O_BOOT_INFO.start_addr == 24'hffff00;
  endproperty
  a_none: assert property (p_none) else $error("no-boot decode wrong");
  property p_hostb;
    O_BOOT_CODE == 4'hd ##1 O_BOOT_CODE == 4'hd |->
      O_BOOT_INFO.boot_src == scb_pkg::SCB_BOOT_HOST && O_BOOT_INFO.start_addr == 24'h010000;
  endproperty
  a_hostb: assert property (p_hostb) else $error("host boot decode wrong");
  c_read: cover property (I_PORT_RD ##1 O_PORT_RVALID);
  c_write: cover property (hit);
  c_host: cover property (O_BOOT_CODE == 4'hd);
endmodule : scb_sysctl_properties

bind scb_sysctl scb_sysctl_properties u_prop (.I_MCLK, .I_NRST, .I_PORT_ADDR, .I_PORT_WR,
  .I_PORT_RD, .I_PORT_WDATA, .O_PORT_RDATA, .O_PORT_RVALID, .O_HOST_PIN_PULL_ENABLE,
  .O_EXT_MEM_BUS_HOLDER_ENABLE, .O_HOST_DATA_BUS_HOLDER_ENABLE, .O_BOOT_INFO, .O_BOOT_CODE);

// ---- verif/scb_strap_model.sv ----
// Purpose: board strap levels on the boot select pins
// Assumes: pins stay straps until the gpio side takes them
// Notes:   after release the low pins toggle every cycle
`timescale 1ns/100ps
module scb_strap_model (
  input  wire logic       i_clk,
  input  wire logic       i_release,
  input  wire logic [3:0] i_code,
  output logic      [2:0] o_low_bits,
  output logic            o_bit3
);
  initial o_low_bits = 3'h0;
  // busy gpio after release, so a late re-capture would show
  always @(posedge i_clk) o_low_bits <= i_release ? ~o_low_bits : i_code[2:0];
  // fourth pin is a plain board level, read while the loader runs
  assign o_bit3 = i_code[3];
endmodule : scb_strap_model

// ---- verif/test_system_control_and_boot_select.sv ----
// Purpose: self-checking bench of the system control block
// Assumes: loader-active high except in the one idle-loader check, strap model on the boot pins
// Notes:   one task each for boot, field and clock scenarios; loader checks inline
`timescale 1ns/100ps
`include "scb_defines.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module test_system_control_and_boot_select;
  logic                       clk   = 1'b0;
  logic                       nrst  = 1'b0;
  logic [15:0]                addr  = 16'h0000;
  logic [15:0]                wdata = 16'h0000;
  logic                       wr_s  = 1'b0;
  logic                       rd_s  = 1'b0;
  logic [3:0]                 strap = 4'h0;
  logic                       ldr   = 1'b1;
  logic [15:0]                rdata;
  logic                       rvalid;
  logic [2:0]                 low;
  logic                       b3;
  logic                       pull;
  logic                       emem;
  logic                       hhold;
  logic                       rel;
  logic [3:0]                 code;
  logic                       clko;
  scb_pkg::scb_boot_info_type info;
  int                         fails = 0;
  int                         n_tests = 0;
  int                         cyc = 0;
  logic [3:0]                 codes [10] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd,
                                             4'he, 4'hf};
  always #4 clk = ~clk;
  scb_sysctl dut (.I_MCLK(clk), .I_NRST(nrst), .I_PORT_ADDR(addr), .I_PORT_WR(wr_s),
    .I_PORT_RD(rd_s), .I_PORT_WDATA(wdata), .O_PORT_RDATA(rdata), .O_PORT_RVALID(rvalid),
    .I_BOOT_SELECT_LOW_BITS(low), .I_BOOT_SELECT_BIT3(b3), .I_BOOT_LOADER_ACTIVE(ldr),
    .O_HOST_PIN_PULL_ENABLE(pull), .O_EXT_MEM_BUS_HOLDER_ENABLE(emem),
    .O_HOST_DATA_BUS_HOLDER_ENABLE(hhold), .O_GPIO_STRAP_RELEASE(rel), .O_BOOT_INFO(info),
    .O_BOOT_CODE(code), .O_CLOCK_OUTPUT_PIN(clko));
  scb_strap_model u_strap (.i_clk(clk), .i_release(rel), .i_code(strap), .o_low_bits(low),
    .o_bit3(b3));
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    tick();
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    tick();
    wr_s = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    tick();
    addr = a;
    rd_s = 1'b1;
    tick();
    rd_s = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask : rd
  // reset with a strap code and check capture, decode and reset values
  task automatic t_boot(input logic [3:0] c);
    scb_pkg::scb_boot_type s;
    logic [23:0]           a;
    s = scb_pkg::SCB_BOOT_NONE;
    a = `SCB_TABLE_START;
    if (c[2:0] == 3'h0) a = `SCB_RESET_VECTOR;
    if (c == 4'hd) a = `SCB_SINGLE_ACCESS_RAM_START;
    case (c)
      4'h1: s = scb_pkg::SCB_BOOT_SPI24;
      4'h9: s = scb_pkg::SCB_BOOT_SPI16;
      4'ha, 4'hb, 4'hc: s = scb_pkg::SCB_BOOT_PAR;
      4'hd: s = scb_pkg::SCB_BOOT_HOST;
      4'he: s = scb_pkg::SCB_BOOT_SER16;
      4'hf: s = scb_pkg::SCB_BOOT_SER8;
      default: s = scb_pkg::SCB_BOOT_NONE;
    endcase
    strap = c;
    nrst = 1'b0;
    repeat (20) tick();
    `CHK(rel, 1'b0)
    nrst = 1'b1;
    repeat (8) tick();
    `CHK(rel, 1'b1)
    `CHK(code, c)
    `CHK(info.boot_src, s)
    `CHK(info.start_addr, a)
    if (s == scb_pkg::SCB_BOOT_PAR) `CHK(info.par_width, 2'(c - 4'ha))
    `CHK({pull, emem, hhold}, 3'b100)
    rd(16'h07fd, {6'h00, 3'b100, c[3], 6'h00});
  endtask : t_boot
  // every writable field, bit 4 kept zero, a foreign address and an unmapped read
  task automatic t_fields;
    wr(16'h07fd, 16'hffef);
    `CHK({pull, emem, hhold}, 3'b111)
    rd(16'h07fd, 16'h03c7);
    wr(16'h07fc, 16'h0000);
    `CHK({pull, emem, hhold}, 3'b111)
    rd(16'h07fc, 16'h0000);
    wr(16'h07fd, 16'h0000);
    `CHK({pull, emem, hhold}, 3'b000)
  endtask : t_fields
  // period of the clock output for one divide code
  task automatic t_clk(input logic [2:0] c);
    realtime t0;
    wr(16'h07fd, {13'h0000, c});
    repeat (40) tick();
    @(posedge clko);
    t0 = $realtime;
    @(posedge clko);
    `CHK(int'($realtime - t0), 8 * ((c == 3'h0) ? 1 : 2 * int'(c)))
  endtask : t_clk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    foreach (codes[i]) t_boot(codes[i]); // reserved codes never strapped
    t_fields();
    t_boot(4'h1);
    strap = 4'h9;
    repeat (8) tick();
    `CHK(code, 4'h9)
    // loader idle: the code keeps its bit 3, the status bit still shows the pin
    ldr = 1'b0;
    strap = 4'h1;
    repeat (8) tick();
    `CHK(code, 4'h9)
    rd(16'h07fd, 16'h0200);
    ldr = 1'b1;
    for (int i = 0; i < 8; i++) t_clk(3'(i));
    conclude();
  end
endmodule : test_system_control_and_boot_select
